// ===== rtl/bsim_cfg.svh
`ifndef BSIM_CFG_SVH
`define BSIM_CFG_SVH

// Instruction register width and codes
`define BSIM_IR_W 10
`define BSIM_IR_BYPASS 10'h3ff
`define BSIM_IR_SAMPLE 10'h005
`define BSIM_IR_EXTEST 10'h00f
`define BSIM_IR_IDCODE 10'h006
`define BSIM_IR_USERCODE 10'h007
`define BSIM_IR_CLAMP 10'h00a
`define BSIM_IR_HIGHZ 10'h00b
// Fixed pattern loaded into the instruction shifter at capture
`define BSIM_IR_CAPTURE 10'h155

// Identification register
`define BSIM_ID_W 32
`define BSIM_SIG_INVALID 32'hffff_ffff

// Boundary cell layout, bit positions inside one cell
`define BSIM_CELL_W 3
`define BSIM_CELL_IN 0
`define BSIM_CELL_OE 1
`define BSIM_CELL_OUT 2

// Reset values
`define BSIM_BYPASS_CAPTURE 1'b0
`define BSIM_TOGGLE_RESET 1'b0

`endif

// ===== rtl/bsim_pkg.sv
package bsim_pkg;

`include "bsim_cfg.svh"

typedef enum logic [3:0] {
    tap_reset, tap_idle,
    tap_sel_dr, tap_cap_dr, tap_shift_dr, tap_exit1_dr, tap_pause_dr, tap_exit2_dr, tap_upd_dr,
    tap_sel_ir, tap_cap_ir, tap_shift_ir, tap_exit1_ir, tap_pause_ir, tap_exit2_ir, tap_upd_ir
} bsim_tap_state_type;

typedef enum logic [1:0] {dr_bypass, dr_boundary, dr_ident, dr_user} bsim_dr_sel_type;

typedef enum logic [1:0] {mode_functional, mode_drive_update, mode_high_z} bsim_pin_mode_type;

// Data register selected by an instruction; unknown codes fall to bypass
function automatic bsim_dr_sel_type bsim_dr_select(input logic [`BSIM_IR_W-1:0] ir);
    case (ir)
        `BSIM_IR_SAMPLE, `BSIM_IR_EXTEST: return dr_boundary;
        `BSIM_IR_IDCODE: return dr_ident;
        `BSIM_IR_USERCODE: return dr_user;
        default: return dr_bypass;
    endcase
endfunction

// Pin source selected by an instruction
function automatic bsim_pin_mode_type bsim_pin_mode(input logic [`BSIM_IR_W-1:0] ir);
    case (ir)
        `BSIM_IR_EXTEST, `BSIM_IR_CLAMP: return mode_drive_update;
        `BSIM_IR_HIGHZ: return mode_high_z;
        default: return mode_functional;
    endcase
endfunction

endpackage

// ===== rtl/bsim_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for levels
module bsim_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

logic [WIDTH-1:0] meta_r;
logic [WIDTH-1:0] sync_r;

// First stage feeds only the second
always_ff @(posedge clk)
begin
    if (reset)
    begin
        meta_r <= '0;
        sync_r <= '0;
    end
    else
    begin
        meta_r <= din;
        sync_r <= meta_r;
    end
end

assign dout = sync_r;

endmodule

`default_nettype wire

// ===== rtl/bsim_tap_fsm.sv
`timescale 1ns/1ps
`default_nettype none

// Sixteen-state test access port controller on rising tck
module bsim_tap_fsm
    import bsim_pkg::*;
(
    input wire logic tck,
    input wire logic reset,
    input wire logic tms,
    output bsim_tap_state_type state
);

bsim_tap_state_type state_r;
bsim_tap_state_type state_nxt;

// Next state from tms
always_comb
begin
    case (state_r)
        tap_reset: state_nxt = tms ? tap_reset : tap_idle;
        tap_idle: state_nxt = tms ? tap_sel_dr : tap_idle;
        tap_sel_dr: state_nxt = tms ? tap_sel_ir : tap_cap_dr;
        tap_cap_dr: state_nxt = tms ? tap_exit1_dr : tap_shift_dr;
        tap_shift_dr: state_nxt = tms ? tap_exit1_dr : tap_shift_dr;
        tap_exit1_dr: state_nxt = tms ? tap_upd_dr : tap_pause_dr;
        tap_pause_dr: state_nxt = tms ? tap_exit2_dr : tap_pause_dr;
        tap_exit2_dr: state_nxt = tms ? tap_upd_dr : tap_shift_dr;
        tap_upd_dr: state_nxt = tms ? tap_sel_dr : tap_idle;
        tap_sel_ir: state_nxt = tms ? tap_reset : tap_cap_ir;
        tap_cap_ir: state_nxt = tms ? tap_exit1_ir : tap_shift_ir;
        tap_shift_ir: state_nxt = tms ? tap_exit1_ir : tap_shift_ir;
        tap_exit1_ir: state_nxt = tms ? tap_upd_ir : tap_pause_ir;
        tap_pause_ir: state_nxt = tms ? tap_exit2_ir : tap_pause_ir;
        tap_exit2_ir: state_nxt = tms ? tap_upd_ir : tap_shift_ir;
        tap_upd_ir: state_nxt = tms ? tap_sel_dr : tap_idle;
        default: state_nxt = tap_reset;
    endcase
end

// State register, power-up in test-logic-reset
always_ff @(posedge tck)
begin
    if (reset)
        state_r <= tap_reset;
    else
        state_r <= state_nxt;
end

assign state = state_r;

endmodule

`default_nettype wire

// ===== rtl/bsim_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "bsim_cfg.svh"

module bsim_top
    import bsim_pkg::*;
#(
    parameter int NUM_IO = 8,
    parameter logic [`BSIM_ID_W-1:0] ID_VALUE = 32'h0a5c_3e01 // Arbitrary value
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [NUM_IO-1:0] core_out,
    input wire logic [NUM_IO-1:0] core_oe,
    input wire logic [NUM_IO-1:0] pin_in,
    output logic [NUM_IO-1:0] pin_out,
    output logic [NUM_IO-1:0] pin_oe,
    input wire logic [NUM_IO-1:0] keeper_select,
    output logic [NUM_IO-1:0] pin_keeper_en,
    input wire logic global_output_enable_pin,
    input wire logic goe_feature_en,
    input wire logic config_done,
    input wire logic [`BSIM_ID_W-1:0] config_flash_block_signature,
    input wire logic signature_reload
);

localparam int BSR_W = `BSIM_CELL_W * NUM_IO;
localparam int SNAP_W = BSR_W + `BSIM_ID_W + 1;

// State of both clock domains; the tck side owns rst_tck, snap_ack_r, snap_hold_r, ir, bsr, id, mode_t and tdo
logic [NUM_IO-1:0] pin_in_s, pin_out_r, pin_oe_r, pin_keeper_en_r;
logic goe_pin_s, sig_valid_r, snap_req_r, snap_ack_s, upd_tgl_s, upd_seen_r;
logic rst_tck, snap_req_s, snap_ack_r, bypass_r, upd_tgl_r, tdo_r, tdo_oe_r, tdo_nxt;
logic [BSR_W-1:0] cap_src, upd_c_r, bsr_r, bsr_upd_r;
logic [`BSIM_ID_W-1:0] user_signature_r, id_sh_r;
logic [SNAP_W-1:0] snap_r, snap_hold_r;
logic [`BSIM_IR_W-1:0] ir_sh_r, ir_r;
bsim_pin_mode_type pmode_r, mode_t_r;
bsim_tap_state_type tap_state;
bsim_dr_sel_type dr_sel;

// Pin inputs and the enable pin arrive asynchronously
bsim_sync #(.WIDTH(NUM_IO + 1)) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .din({global_output_enable_pin, pin_in}),
    .dout({goe_pin_s, pin_in_s})
);

// Handshake toggles crossing into the system domain
bsim_sync #(.WIDTH(2)) u_to_clk_sync (
    .clk(clk),
    .reset(reset),
    .din({snap_ack_r, upd_tgl_r}),
    .dout({snap_ack_s, upd_tgl_s})
);

// Reset and snapshot request crossing into the tck domain
bsim_sync #(.WIDTH(2)) u_to_tck_sync (
    .clk(tck),
    .reset(1'b0),
    .din({reset, snap_req_r}),
    .dout({rst_tck, snap_req_s})
);

// Capture sources per cell: core data, active-low core enable, pin level
genvar gi;
generate
    for (gi = 0; gi < NUM_IO; gi++)
    begin : g_cell
        assign cap_src[gi*`BSIM_CELL_W + `BSIM_CELL_OUT] = core_out[gi];
        assign cap_src[gi*`BSIM_CELL_W + `BSIM_CELL_OE] = ~core_oe[gi];
        assign cap_src[gi*`BSIM_CELL_W + `BSIM_CELL_IN] = pin_in_s[gi];
    end
endgenerate

// Volatile user signature, refreshed only by a reload
always_ff @(posedge clk)
begin
    if (reset)
    begin
        user_signature_r <= `BSIM_SIG_INVALID;
        sig_valid_r <= 1'b0;
    end
    else
    begin
        if (signature_reload)
            user_signature_r <= config_flash_block_signature;
        sig_valid_r <= config_done;
    end
end

// Snapshot offered to the tck domain; held until acknowledged
always_ff @(posedge clk)
begin
    if (reset)
    begin
        snap_r <= '0;
        snap_req_r <= `BSIM_TOGGLE_RESET;
    end
    else if (snap_ack_s == snap_req_r)
    begin
        snap_r <= {sig_valid_r, user_signature_r, cap_src};
        snap_req_r <= ~snap_req_r;
    end
end

// Take over mode and update cells when the tck side signals a change
always_ff @(posedge clk)
begin
    if (reset)
    begin
        upd_seen_r <= `BSIM_TOGGLE_RESET;
        pmode_r <= mode_functional;
        upd_c_r <= '0;
    end
    else if (upd_tgl_s != upd_seen_r)
    begin
        upd_seen_r <= upd_tgl_s;
        pmode_r <= mode_t_r;
        upd_c_r <= bsr_upd_r;
    end
end

// Pin drivers per mode
always_ff @(posedge clk)
begin
    if (reset)
    begin
        pin_out_r <= '0;
        pin_oe_r <= '0;
    end
    else
    begin
        for (int i = 0; i < NUM_IO; i++)
        begin
            case (pmode_r)
                mode_drive_update:
                begin
                    pin_out_r[i] <= upd_c_r[i*`BSIM_CELL_W + `BSIM_CELL_OUT];
                    pin_oe_r[i] <= ~upd_c_r[i*`BSIM_CELL_W + `BSIM_CELL_OE];
                end
                mode_high_z: {pin_out_r[i], pin_oe_r[i]} <= 2'b00;
                default:
                begin
                    pin_out_r[i] <= core_out[i];
                    pin_oe_r[i] <= core_oe[i] & (~goe_feature_en | goe_pin_s);
                end
            endcase
        end
    end
end

// Keepers follow configuration in every mode
always_ff @(posedge clk)
begin
    if (reset)
        pin_keeper_en_r <= '0;
    else
        pin_keeper_en_r <= keeper_select;
end

// Test access port controller
bsim_tap_fsm u_tap (
    .tck(tck),
    .reset(rst_tck),
    .tms(tms),
    .state(tap_state)
);

assign dr_sel = bsim_dr_select(ir_r);

// Accept a fresh snapshot whenever one is offered
always_ff @(posedge tck)
begin
    if (rst_tck)
    begin
        snap_hold_r <= '0;
        snap_ack_r <= `BSIM_TOGGLE_RESET;
    end
    else if (snap_req_s != snap_ack_r)
    begin
        snap_hold_r <= snap_r;
        snap_ack_r <= snap_req_s;
    end
end

// Instruction shifter and current instruction
always_ff @(posedge tck)
begin
    if (rst_tck)
    begin
        ir_sh_r <= `BSIM_IR_CAPTURE;
        ir_r <= `BSIM_IR_IDCODE;
    end
    else
    begin
        case (tap_state)
            tap_reset: ir_r <= `BSIM_IR_IDCODE;
            tap_cap_ir: ir_sh_r <= `BSIM_IR_CAPTURE;
            tap_shift_ir: ir_sh_r <= {tdi, ir_sh_r[`BSIM_IR_W-1:1]};
            tap_upd_ir: ir_r <= ir_sh_r;
            default: ir_sh_r <= ir_sh_r;
        endcase
    end
end

// Boundary chain: capture, shift, update
always_ff @(posedge tck)
begin
    if (rst_tck)
    begin
        bsr_r <= '0;
        bsr_upd_r <= '0;
    end
    else if (dr_sel == dr_boundary)
    begin
        case (tap_state)
            tap_cap_dr: bsr_r <= snap_hold_r[BSR_W-1:0];
            tap_shift_dr: bsr_r <= {tdi, bsr_r[BSR_W-1:1]};
            tap_upd_dr: bsr_upd_r <= bsr_r;
            default: bsr_r <= bsr_r;
        endcase
    end
end

// Bypass cell
always_ff @(posedge tck)
begin
    if (rst_tck)
        bypass_r <= `BSIM_BYPASS_CAPTURE;
    else if (dr_sel == dr_bypass && tap_state == tap_cap_dr)
        bypass_r <= `BSIM_BYPASS_CAPTURE;
    else if (dr_sel == dr_bypass && tap_state == tap_shift_dr)
        bypass_r <= tdi;
end

// Identification register, shared by identification and user-code
always_ff @(posedge tck)
begin
    if (rst_tck)
        id_sh_r <= ID_VALUE;
    else if (dr_sel == dr_ident || dr_sel == dr_user)
    begin
        if (tap_state == tap_cap_dr)
        begin
            if (dr_sel == dr_ident)
                id_sh_r <= ID_VALUE;
            else if (snap_hold_r[SNAP_W-1])
                id_sh_r <= snap_hold_r[BSR_W +: `BSIM_ID_W];
            else
                id_sh_r <= `BSIM_SIG_INVALID;
        end
        else if (tap_state == tap_shift_dr)
            id_sh_r <= {tdi, id_sh_r[`BSIM_ID_W-1:1]};
    end
end

// Pin mode and change toggle handed to the system domain
always_ff @(posedge tck)
begin
    if (rst_tck)
    begin
        mode_t_r <= mode_functional;
        upd_tgl_r <= `BSIM_TOGGLE_RESET;
    end
    else
    begin
        case (tap_state)
            tap_reset:
                if (mode_t_r != mode_functional)
                begin
                    mode_t_r <= mode_functional;
                    upd_tgl_r <= ~upd_tgl_r;
                end
            tap_upd_ir:
            begin
                mode_t_r <= bsim_pin_mode(ir_sh_r);
                upd_tgl_r <= ~upd_tgl_r;
            end
            tap_upd_dr:
                if (dr_sel == dr_boundary)
                    upd_tgl_r <= ~upd_tgl_r;
            default: upd_tgl_r <= upd_tgl_r;
        endcase
    end
end

// Serial output source
always_comb
begin
    tdo_nxt = tdo_r;
    if (tap_state == tap_shift_ir)
        tdo_nxt = ir_sh_r[0];
    else if (tap_state == tap_shift_dr)
    begin
        case (dr_sel)
            dr_boundary: tdo_nxt = bsr_r[0];
            dr_ident, dr_user: tdo_nxt = id_sh_r[0];
            default: tdo_nxt = bypass_r;
        endcase
    end
end

// Output driver switched on falling tck
always_ff @(negedge tck)
begin
    if (rst_tck)
    begin
        tdo_r <= 1'b0;
        tdo_oe_r <= 1'b0;
    end
    else
    begin
        tdo_r <= tdo_nxt;
        tdo_oe_r <= (tap_state == tap_shift_ir) || (tap_state == tap_shift_dr);
    end
end

assign tdo = tdo_r;
assign tdo_oe = tdo_oe_r;
assign pin_out = pin_out_r;
assign pin_oe = pin_oe_r;
assign pin_keeper_en = pin_keeper_en_r;

endmodule

`default_nettype wire

// ===== test/bsim_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the scan block
module bsim_top_chk #(
    parameter int NUM_IO = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [NUM_IO-1:0] core_out,
    input wire logic [NUM_IO-1:0] pin_out,
    input wire logic [NUM_IO-1:0] pin_oe,
    input wire logic [NUM_IO-1:0] keeper_select,
    input wire logic [NUM_IO-1:0] pin_keeper_en
);
    // Pin side, system clock
    rst_pins_a: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> pin_out == '0 && pin_oe == '0 && pin_keeper_en == '0)
        else $error("pins not cleared by reset");
    rel_func_a: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |=> pin_out == $past(core_out))
        else $error("pins not functional after reset");
    keeper_a: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> pin_keeper_en == $past(keeper_select))
        else $error("keeper enable not following its select");
    // Serial side, link clock
    oe_off_a: assert property (@(posedge tck) disable iff (reset)
        tms |=> !tdo_oe)
        else $error("tdo driven outside shift");
    oe_hold_a: assert property (@(posedge tck) disable iff (reset)
        tdo_oe && !tms |=> tdo_oe)
        else $error("shift left with tms low");
    oe_rise_a: assert property (@(posedge tck) disable iff (reset)
        $rose(tdo_oe) |-> !$past(tms))
        else $error("tdo enabled without shift entry");
    fsm_path_a: assert property (@(posedge tck) disable iff (reset)
        tms [*5] ##1 !tms ##1 tms ##1 !tms [*2] |=> tdo_oe)
        else $error("controller not resynchronised by tms highs");
    tdo_hold_a: assert property (@(negedge tck) disable iff (reset)
        !tdo_oe && !$past(tdo_oe) |-> $stable(tdo))
        else $error("tdo moved while released");
    cover property (@(posedge tck) disable iff (reset) $rose(tdo_oe));
    cover property (@(posedge clk) disable iff (reset) $changed(pin_oe));
    cover property (@(posedge clk) disable iff (reset) $changed(pin_keeper_en));
endmodule

bind bsim_top bsim_top_chk #(.NUM_IO(NUM_IO)) i_bsim_top_chk (
    .clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
    .pin_out(pin_out), .pin_oe(pin_oe), .keeper_select(keeper_select), .pin_keeper_en(pin_keeper_en));

`default_nettype wire

// ===== test/bsim_tester.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural scan tester; tck idles low between frames
module bsim_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo_w
);
    // Idle levels follow the pin pulls
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One tck pulse; tdo taken at the rising edge
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #20;
        o = tdo_w;
        tck = 1'b1;
        #40;
        tck = 1'b0;
        #20;
    endtask

    // Tms high n times, then to idle
    task automatic resync(input int n);
        logic o;
        repeat (n) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask

    // Idle ticks so the capture snapshot handshake catches up with new pin data
    task automatic run(input int n);
        logic o;
        repeat (n) tick(1'b0, 1'b1, o);
    endtask

    // Scan from idle; ir picks the instruction path
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b1, o);
        if (ir)
            tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask
endmodule

`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "bsim_cfg.svh"

module tb_top;
    localparam int NIO = 4;
    localparam int CW = 3 * NIO;
    localparam logic [31:0] ID = 32'h1357_2468; // Arbitrary value
    logic clk, reset, tck, tms, tdi, tdo, tdo_oe;
    logic [NIO-1:0] core_out, core_oe, pin_in, pin_out, pin_oe, keep_sel, keep_en;
    logic goe_pin, goe_en, cfg_done, reload;
    logic [31:0] flash_sig, rd, pat, din, ex;
    logic [31:0] seed = 32'h007d;
    logic [9:0] codes [4] = '{`BSIM_IR_CLAMP, `BSIM_IR_HIGHZ, `BSIM_IR_BYPASS, 10'h2c4};
    int n_errors = 0;
    int cmp_count = 0;
    wire logic tdo_w = tdo_oe ? tdo : ~tdo; // Released line shows the inverse

    bsim_top #(.NUM_IO(NIO), .ID_VALUE(ID)) i_bsim_top (.clk(clk), .reset(reset), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .keeper_select(keep_sel), .pin_keeper_en(keep_en),
        .global_output_enable_pin(goe_pin), .goe_feature_en(goe_en), .config_done(cfg_done),
        .config_flash_block_signature(flash_sig), .signature_reload(reload));
    bsim_tester i_bsim_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo_w(tdo_w));

    // System clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected capture: input, inverted enable, data per cell
    function automatic logic [31:0] cap();
        logic [31:0] c;
        c = '0;
        for (int i = 0; i < NIO; i++)
            c[3*i +: 3] = {core_out[i], ~core_oe[i], pin_in[i]};
        return c;
    endfunction

    // Expected pins driven from an update pattern
    function automatic logic [31:0] pexp(input logic [31:0] p);
        logic [NIO-1:0] o, e;
        for (int i = 0; i < NIO; i++)
        begin
            o[i] = p[3*i+2];
            e[i] = ~p[3*i+1];
        end
        return 32'({o, e});
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic setio();
        step(1);
        rd = rnd();
        {keep_sel, pin_in, core_oe, core_out} = rd[15:0];
        step(6);
        i_bsim_tester.run(6);
    endtask

    task automatic pulse(input logic [31:0] s);
        step(1);
        flash_sig = s;
        reload = 1'b1;
        step(1);
        reload = 1'b0;
        step(6);
        i_bsim_tester.run(6);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog, well beyond the expected run
    initial
    begin
        #400000;
        n_errors++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        reset = 1'b1;
        {core_out, core_oe, pin_in, keep_sel} = '0;
        {goe_pin, cfg_done, reload} = '0;
        goe_en = 1'b1;
        flash_sig = '0;
        fork
            i_bsim_tester.resync(7);
            step(16);
        join
        step(1);
        reset = 1'b0;
        i_bsim_tester.resync(5);
        i_bsim_tester.scan(1'b0, 32, rnd(), rd);
        check(rd, ID);
        i_bsim_tester.scan(1'b1, 10, 32'(`BSIM_IR_SAMPLE), rd);
        check(rd, 32'(`BSIM_IR_CAPTURE));
        $display("identification test done");
        setio();
        pat = rnd() & 32'hfff;
        ex = (pat << CW) | cap();
        i_bsim_tester.scan(1'b0, 2 * CW, (pat << CW) | pat, rd);
        check(rd, ex);
        step(6);
        check(32'({pin_out, pin_oe}), 32'({core_out, {NIO{1'b0}}}));
        $display("sample test done");
        i_bsim_tester.scan(1'b1, 10, 32'(`BSIM_IR_EXTEST), rd);
        step(6);
        check(32'({pin_out, pin_oe}), pexp(pat));
        pin_in = pin_out;
        step(6);
        i_bsim_tester.run(6);
        ex = cap();
        pat = rnd() & 32'hfff;
        i_bsim_tester.scan(1'b0, CW, pat, rd);
        check(rd, ex);
        step(6);
        check(32'({pin_out, pin_oe}), pexp(pat));
        $display("external test done");
        step(1);
        goe_pin = 1'b1;
        foreach (codes[k])
        begin
            i_bsim_tester.scan(1'b1, 10, 32'(codes[k]), rd);
            step(6);
            ex = codes[k] == `BSIM_IR_CLAMP ? pexp(pat) : codes[k] == `BSIM_IR_HIGHZ ? 32'h0 : 32'({core_out, core_oe});
            check(32'({pin_out, pin_oe}), ex);
            check(32'(keep_en), 32'(keep_sel));
            din = rnd() & 32'hff;
            i_bsim_tester.scan(1'b0, 8, din, rd);
            check(rd, (din << 1) & 32'hff);
        end
        $display("bypass modes test done");
        i_bsim_tester.scan(1'b1, 10, 32'(`BSIM_IR_USERCODE), rd);
        pulse(rnd());
        ex = flash_sig;
        i_bsim_tester.scan(1'b0, 32, 32'h0, rd);
        check(rd, 32'hffff_ffff);
        step(1);
        cfg_done = 1'b1;
        flash_sig = rnd();
        step(6);
        i_bsim_tester.run(6);
        i_bsim_tester.scan(1'b0, 32, 32'h0, rd);
        check(rd, ex);
        pulse(rnd());
        i_bsim_tester.scan(1'b0, 32, 32'h0, rd);
        check(rd, flash_sig);
        $display("user code test done");
        i_bsim_tester.scan(1'b1, 10, 32'(`BSIM_IR_CLAMP), rd);
        i_bsim_tester.resync(5);
        step(1);
        goe_pin = 1'b0;
        goe_en = 1'b0;
        step(6);
        check(32'({pin_out, pin_oe}), 32'({core_out, core_oe}));
        i_bsim_tester.scan(1'b0, 32, 32'h0, rd);
        check(rd, ID);
        $display("resync test done");
        finish_test();
    end
endmodule

`default_nettype wire
